// ===== rtl/rsso_consts.svh
// offsets, field positions, reset values and counts of the rotate/subtract/sleep block
`ifndef RSSO_CONSTS_SVH
`define RSSO_CONSTS_SVH

`define RSSO_ADDR_W 5
`define RSSO_OFS_ACC 5'h00
`define RSSO_OFS_STATUS 5'h04
`define RSSO_OFS_INSTR 5'h08
`define RSSO_OFS_WDOG 5'h0c
`define RSSO_OFS_PTR 5'h10
`define RSSO_OFS_FDATA 5'h14

`define RSSO_FILE_DEPTH 128
`define RSSO_INSTR_MSB 17
`define RSSO_STAT_MSB 4
`define RSSO_STAT_SW_MSB 2
`define RSSO_WDOG_PRE_LSB 8
`define RSSO_PTR_MSB 6

`define RSSO_ACC_RST 8'h00
`define RSSO_STAT_RST 5'h18
`define RSSO_PTR_RST 7'h00
`define RSSO_WDOG_CLR 8'h00
`define RSSO_RDATA_RST 32'h00000000
`define RSSO_HALF_BORROW_MSB 3

`endif

// ===== rtl/rsso_pkg.sv
// types of the rotate/subtract/sleep block
package rsso_pkg;

    typedef enum logic [1:0] {
        RSSO_OP_ROTL = 2'b00,
        RSSO_OP_ROTR = 2'b01,
        RSSO_OP_LITSUB = 2'b10,
        RSSO_OP_SLEEP = 2'b11
    } rsso_op_type;

    typedef enum logic {
        RSSO_RUN = 1'b0,
        RSSO_HALT = 1'b1
    } rsso_state_type;

    typedef struct packed {
        rsso_op_type op;
        logic destFile;
        logic [6:0] fileAddr;
        logic [7:0] literal;
    } rsso_instr_type;

    typedef struct packed {
        logic timeOut;
        logic powerDown;
        logic zero;
        logic halfBorrow;
        logic carry;
    } rsso_status_type;

    typedef struct packed {
        rsso_op_type op;
        logic [7:0] operand;
        logic [7:0] acc;
        logic [7:0] literal;
        logic carryIn;
    } rsso_alu_in_type;

    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic halfBorrow;
        logic zero;
    } rsso_alu_out_type;

endpackage

// ===== rtl/rsso_alu.sv
// combinational rotate and literal-minus-accumulator datapath
`timescale 1ns/1ps
`include "rsso_consts.svh"
module rsso_alu (
    input rsso_pkg::rsso_alu_in_type aluIn,
    output rsso_pkg::rsso_alu_out_type aluOut
);
    import rsso_pkg::*;

    function automatic logic [8:0] litMinusAcc(input logic [7:0] lit, input logic [7:0] acc);
        logic [8:0] diff;
        diff = {1'b0, lit} - {1'b0, acc};
        litMinusAcc = {~diff[8], diff[7:0]};
    endfunction

    always_comb begin
        logic [8:0] sub;
        sub = litMinusAcc(aluIn.literal, aluIn.acc);
        aluOut.result = aluIn.operand;
        aluOut.carry = aluIn.carryIn;
        aluOut.halfBorrow = 1'b0;
        aluOut.zero = 1'b0;
        case (aluIn.op)
            RSSO_OP_ROTL: begin
                aluOut.result = {aluIn.operand[6:0], aluIn.carryIn}; // RL1
                aluOut.carry = aluIn.operand[7]; // RL1
            end
            RSSO_OP_ROTR: begin
                aluOut.result = {aluIn.carryIn, aluIn.operand[7:1]}; // RL3
                aluOut.carry = aluIn.operand[0]; // RL3
            end
            RSSO_OP_LITSUB: begin
                aluOut.result = sub[7:0]; // RL7
                aluOut.carry = sub[8]; // RL8
                aluOut.halfBorrow = aluIn.literal[`RSSO_HALF_BORROW_MSB:0]
                    >= aluIn.acc[`RSSO_HALF_BORROW_MSB:0]; // RL8
                aluOut.zero = (sub[7:0] == 8'h00); // RL9
            end
            default: begin
                aluOut.result = aluIn.operand;
            end
        endcase
    end
endmodule

// ===== rtl/rsso_core.sv
// rotate/subtract/sleep execution block with avalon-mm register slave
// Behaviour
// RL1: rotate-left moves file register bits up, carry into bit 0, bit 7 out.
// RL2: destination select 0 writes accumulator, 1 writes the file register.
// RL3: rotate-right moves bits down, carry into bit 7, bit 0 out; only carry changes.
// RL4: sleep clears the watchdog counter and its prescaler.
// RL5: sleep clears the power-down flag and sets the time-out flag.
// RL6: sleep halts with the oscillator stopped; nothing executes until wake-up.
// RL7: literal-minus-accumulator puts the 8-bit two's complement difference into accumulator.
// RL8: carry is 0 when acc exceeds literal; half flag likewise on low nibbles.
// RL9: literal-minus-accumulator sets zero flag exactly when the result is zero.
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "rsso_consts.svh"
module rsso_core #(
    parameter int PRE_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [`RSSO_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wakeUp,
    output logic oscStopped
);
    import rsso_pkg::*;

    if (PRE_W < 1 || PRE_W > 24) begin : g_bad_pre
        $error("PRE_W must lie between 1 and 24");
    end

    logic waitReg, waitNext;
    logic [31:0] rdataReg, rdataNext;
    logic [7:0] accReg, accNext;
    rsso_status_type statReg, statNext;
    logic [6:0] ptrReg, ptrNext;
    rsso_state_type stateReg, stateNext;
    logic oscStopReg, oscStopNext;
    logic [7:0] wdtReg, wdtNext;
    logic [PRE_W-1:0] preReg, preNext;
    logic [23:0] preWide;
    logic [7:0] fileMem [0:`RSSO_FILE_DEPTH-1];
    logic fileWe;
    logic [6:0] fileWaddr;
    logic [7:0] fileWdata;

    logic accept, wrAccept, exec;
    rsso_instr_type instr;
    logic [7:0] fileRd;
    rsso_alu_in_type aluIn;
    rsso_alu_out_type aluOut;

    assign accept = ce && (avs_read || avs_write) && !waitReg;
    assign wrAccept = accept && avs_write;
    assign instr = rsso_instr_type'(avs_writedata[`RSSO_INSTR_MSB:0]);
    assign exec = wrAccept && avs_address == `RSSO_OFS_INSTR && stateReg == RSSO_RUN; // RL6
    assign fileRd = fileMem[instr.fileAddr];
    assign preWide = 24'(preReg);

    assign aluIn.op = instr.op;
    assign aluIn.operand = fileRd;
    assign aluIn.acc = accReg;
    assign aluIn.literal = instr.literal;
    assign aluIn.carryIn = statReg.carry;

    rsso_alu u_alu (
        .aluIn(aluIn),
        .aluOut(aluOut)
    );

    always_comb begin
        waitNext = !((avs_read || avs_write) && waitReg);
        rdataNext = rdataReg;
        accNext = accReg;
        statNext = statReg;
        ptrNext = ptrReg;
        stateNext = stateReg;
        wdtNext = wdtReg;
        preNext = preReg;
        fileWe = 1'b0;
        fileWaddr = ptrReg;
        fileWdata = avs_writedata[7:0];
        // watchdog runs only while the oscillator runs
        if (stateReg == RSSO_RUN) begin
            preNext = preReg + 1'b1;
            if (&preReg) begin
                wdtNext = wdtReg + 8'h01;
            end
        end else if (wakeUp) begin
            stateNext = RSSO_RUN;
        end
        // read data prepared one cycle ahead of the accepting edge
        if (avs_read && waitReg) begin
            case (avs_address)
                `RSSO_OFS_ACC: rdataNext = {24'h000000, accReg};
                `RSSO_OFS_STATUS: rdataNext = {27'h0, statReg};
                `RSSO_OFS_WDOG: rdataNext = {8'h00, preWide[15:0], wdtReg};
                `RSSO_OFS_PTR: rdataNext = {25'h0, ptrReg};
                `RSSO_OFS_FDATA: rdataNext = {24'h000000, fileMem[ptrReg]};
                default: rdataNext = `RSSO_RDATA_RST;
            endcase
        end
        if (wrAccept) begin
            case (avs_address)
                `RSSO_OFS_ACC: accNext = avs_writedata[7:0];
                `RSSO_OFS_STATUS: begin
                    statNext.zero = avs_writedata[2];
                    statNext.halfBorrow = avs_writedata[1];
                    statNext.carry = avs_writedata[0];
                end
                `RSSO_OFS_PTR: ptrNext = avs_writedata[`RSSO_PTR_MSB:0];
                `RSSO_OFS_FDATA: fileWe = 1'b1;
                default: begin
                end
            endcase
        end
        if (exec) begin
            case (instr.op)
                RSSO_OP_ROTL, RSSO_OP_ROTR: begin
                    statNext.carry = aluOut.carry; // RL3
                    if (instr.destFile) begin
                        fileWe = 1'b1; // RL2
                        fileWaddr = instr.fileAddr;
                        fileWdata = aluOut.result;
                    end else begin
                        accNext = aluOut.result; // RL2
                    end
                end
                RSSO_OP_LITSUB: begin
                    accNext = aluOut.result; // RL7
                    statNext.carry = aluOut.carry; // RL8
                    statNext.halfBorrow = aluOut.halfBorrow; // RL8
                    statNext.zero = aluOut.zero; // RL9
                end
                RSSO_OP_SLEEP: begin
                    wdtNext = `RSSO_WDOG_CLR; // RL4
                    preNext = '0; // RL4
                    statNext.timeOut = 1'b1; // RL5
                    statNext.powerDown = 1'b0; // RL5
                    stateNext = RSSO_HALT; // RL6
                end
                default: begin
                end
            endcase
        end
        oscStopNext = (stateNext == RSSO_HALT); // RL6
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            waitReg <= 1'b1;
            rdataReg <= `RSSO_RDATA_RST;
            accReg <= `RSSO_ACC_RST;
            statReg <= `RSSO_STAT_RST;
            ptrReg <= `RSSO_PTR_RST;
            stateReg <= RSSO_RUN;
            oscStopReg <= 1'b0;
            wdtReg <= `RSSO_WDOG_CLR;
            preReg <= '0;
        end else if (ce) begin
            waitReg <= waitNext;
            rdataReg <= rdataNext;
            accReg <= accNext;
            statReg <= statNext;
            ptrReg <= ptrNext;
            stateReg <= stateNext;
            oscStopReg <= oscStopNext;
            wdtReg <= wdtNext;
            preReg <= preNext;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce && fileWe) begin
            fileMem[fileWaddr] <= fileWdata;
        end
    end

    assign avs_readdata = rdataReg;
    assign avs_waitrequest = waitReg;
    assign oscStopped = oscStopReg;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence sRotl;
        exec && instr.op == RSSO_OP_ROTL;
    endsequence
    sequence sRotr;
        exec && instr.op == RSSO_OP_ROTR;
    endsequence
    sequence sSub;
        exec && instr.op == RSSO_OP_LITSUB;
    endsequence
    sequence sSleep;
        exec && instr.op == RSSO_OP_SLEEP;
    endsequence
    sequence sHaltHeld;
        (stateReg == RSSO_HALT && !wakeUp && ce)[*3];
    endsequence

    chk_rotl_value: assert property (sRotl ##0 !instr.destFile |=> // RL1
        accReg == {$past(fileRd[6:0]), $past(statReg.carry)} && statReg.carry == $past(fileRd[7]))
        else $error("rotate-left value or carry wrong");
    chk_dest_file: assert property (sRotl ##0 instr.destFile |=> // RL2
        $stable(accReg) && fileMem[$past(instr.fileAddr)] == {$past(fileRd[6:0]),
        $past(statReg.carry)})
        else $error("rotate result not written to file register");
    chk_rotr_value: assert property (sRotr |=> // RL3
        statReg.carry == $past(fileRd[0]) && $stable(statReg.zero) && $stable(statReg.halfBorrow))
        else $error("rotate-right changed more than carry");
    chk_sleep_wdog: assert property (sSleep |=> wdtReg == 8'h00 && preReg == '0 // RL4
        ##1 (!ce || wdtReg == 8'h00))
        else $error("sleep did not clear watchdog");
    chk_sleep_flags: assert property (sSleep |=> statReg.timeOut && !statReg.powerDown) // RL5
        else $error("sleep flags wrong");
    chk_sleep_halt: assert property (sSleep |=> oscStopped && stateReg == RSSO_HALT) // RL6
        else $error("core not halted after sleep");
    chk_halt_frozen: assert property (sHaltHeld ##0 !wrAccept |=> // RL6
        oscStopped && $stable(accReg) && $stable(statReg) && $stable(wdtReg) && $stable(preReg))
        else $error("state changed while halted");
    chk_sub_result: assert property (sSub |=> accReg == 8'($past(instr.literal) // RL7
        - $past(accReg)))
        else $error("literal minus accumulator wrong");
    chk_sub_carry: assert property (sSub |=> // RL8
        statReg.carry == ($past(accReg) <= $past(instr.literal)) &&
        statReg.halfBorrow == ($past(accReg[3:0]) <= $past(instr.literal[3:0])))
        else $error("subtract carry or half flag wrong");
    chk_sub_zero: assert property (sSub |=> statReg.zero == (accReg == 8'h00)) // RL9
        else $error("subtract zero flag wrong");
    chk_bus_answer: assert property ((avs_read || avs_write) && waitReg && ce |=> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");
endmodule

// ===== verif/rsso_core_test.sv
// self-checking bench of the rotate/subtract/sleep block
`timescale 1ns/1ps
`include "rsso_consts.svh"
module rsso_core_test;
    import rsso_pkg::*;

    typedef struct packed {
        logic [1:0] op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] lit;
        logic [7:0] acc;
        logic [2:0] st;
        logic [7:0] file;
        logic [7:0] eAcc;
        logic [2:0] eSt;
        logic [7:0] eFile;
    } rsso_row_type;

    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic ce = 1'b1;
    logic [4:0] avsAddress = 5'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h00000000;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic wakeUp = 1'b0;
    logic oscStopped;
    int nErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    logic [31:0] q;
    rsso_row_type rows [8] = '{
        '{2'b00, 1'b0, 7'h05, 8'h00, 8'h00, 3'h6, 8'he6, 8'hcc, 3'h7, 8'he6},
        '{2'b00, 1'b1, 7'h7f, 8'h00, 8'h55, 3'h1, 8'h01, 8'h55, 3'h0, 8'h03},
        '{2'b01, 1'b0, 7'h00, 8'h00, 8'h00, 3'h1, 8'h01, 8'h80, 3'h1, 8'h01},
        '{2'b01, 1'b1, 7'h40, 8'h00, 8'h33, 3'h6, 8'h80, 8'h33, 3'h6, 8'h40},
        '{2'b10, 1'b0, 7'h01, 8'h10, 8'h10, 3'h0, 8'h00, 8'h00, 3'h7, 8'h00},
        '{2'b10, 1'b0, 7'h01, 8'h05, 8'h06, 3'h7, 8'h00, 8'hff, 3'h0, 8'h00},
        '{2'b10, 1'b0, 7'h01, 8'h20, 8'h01, 3'h0, 8'h00, 8'h1f, 3'h1, 8'h00},
        '{2'b10, 1'b0, 7'h01, 8'h0f, 8'hf0, 3'h0, 8'h00, 8'h1f, 3'h2, 8'h00}
    };

    rsso_core #(.PRE_W(2)) uut (
        .mclk(mclk),
        .sys_rst(sysRst),
        .ce(ce),
        .avs_address(avsAddress),
        .avs_read(avsRead),
        .avs_write(avsWrite),
        .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .wakeUp(wakeUp),
        .oscStopped(oscStopped)
    );

    always #2 mclk = ~mclk;

    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            giveVerdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon access, held until accepted, released after
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWritedata <= d;
        avsRead <= !wr;
        avsWrite <= wr;
        do @(posedge mclk); while (!(avsWaitrequest === 1'b0 && ce === 1'b1));
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic instr(input logic [1:0] op, input logic dst, input logic [6:0] a,
        input logic [7:0] lit);
        xfer(1'b1, `RSSO_OFS_INSTR, {14'h0000, op, dst, a, lit});
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, oscStopped}, 32'h0);
        xfer(1'b0, `RSSO_OFS_STATUS, 32'h0);
        chk(q, 32'h18);
        xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(1'b1, `RSSO_OFS_ACC, {24'h0, rows[i].acc});
            xfer(1'b1, `RSSO_OFS_STATUS, {29'h0, rows[i].st});
            xfer(1'b1, `RSSO_OFS_PTR, {25'h0, rows[i].addr});
            xfer(1'b1, `RSSO_OFS_FDATA, {24'h0, rows[i].file});
            instr(rows[i].op, rows[i].dest, rows[i].addr, rows[i].lit);
            xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
            chk(q, {24'h0, rows[i].eAcc});
            xfer(1'b0, `RSSO_OFS_STATUS, 32'h0);
            chk(q, {27'h3, rows[i].eSt});
            xfer(1'b0, `RSSO_OFS_FDATA, 32'h0);
            chk(q, {24'h0, rows[i].eFile});
            $display("test row %0d done", i);
        end
        repeat (40) @(posedge mclk);
        instr(2'b11, 1'b0, 7'h00, 8'h00);
        chk({31'h0, oscStopped}, 32'h1);
        xfer(1'b0, `RSSO_OFS_STATUS, 32'h0);
        chk(q, 32'h12);
        xfer(1'b0, `RSSO_OFS_WDOG, 32'h0);
        chk(q, 32'h0);
        instr(2'b10, 1'b0, 7'h00, 8'h77);
        xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
        chk(q, 32'h1f);
        wakeUp <= 1'b1;
        for (int n = 0; n < 20 && oscStopped !== 1'b0; n++) @(posedge mclk);
        wakeUp <= 1'b0;
        chk({31'h0, oscStopped}, 32'h0);
        instr(2'b10, 1'b0, 7'h00, 8'h1f);
        xfer(1'b0, `RSSO_OFS_STATUS, 32'h0);
        chk(q, 32'h17);
        $display("test sleep done");
        xfer(1'b1, 5'h1c, 32'hffffffff);
        xfer(1'b0, 5'h1c, 32'h0);
        chk(q, 32'h0);
        ce <= 1'b0;
        fork
            begin
                repeat (3) @(posedge mclk);
                ce <= 1'b1;
            end
        join_none
        xfer(1'b1, `RSSO_OFS_ACC, 32'h000000a5);
        xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
        chk(q, 32'ha5);
        $display("test bus corners done");
        instr(2'b11, 1'b0, 7'h00, 8'h00);
        chk({31'h0, oscStopped}, 32'h1);
        sysRst <= 1'b1;
        repeat (2) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, oscStopped}, 32'h0);
        xfer(1'b0, `RSSO_OFS_STATUS, 32'h0);
        chk(q, 32'h18);
        xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
        chk(q, 32'h0);
        instr(2'b10, 1'b0, 7'h00, 8'h03);
        xfer(1'b0, `RSSO_OFS_ACC, 32'h0);
        chk(q, 32'h3);
        $display("test mid-run reset done");
        giveVerdict();
    end
endmodule
